/* File: src/acs_regs.svh */
// register offsets, field positions, reset values and timing counts
// for the converter setup block; included by the modules and the bench
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// register indices (printed offsets), byte address is four times these
`define ACS_IDX_CH2_A      8'h05
`define ACS_IDX_CH2_B      8'h06
`define ACS_IDX_TEMP_A     8'h08
`define ACS_IDX_TEMP_B     8'h09
`define ACS_IDX_CTRL       8'h0C
`define ACS_IDX_STATUS     8'h0D

// setup register A fields
`define ACS_GAIN_MSB       15
`define ACS_GAIN_LSB       11
`define ACS_CLK_MSB        10
`define ACS_CLK_LSB        8
`define ACS_RES_MSB        6
`define ACS_RES_LSB        4
`define ACS_OFS_SIGN       3
`define ACS_OFS_MSB        2
`define ACS_OFS_LSB        0
// setup register B fields
`define ACS_BIAS_MSB       6
`define ACS_BIAS_LSB       4
`define ACS_REF_MSB        1
`define ACS_REF_LSB        0

// writable bit masks
`define ACS_MASK_A         16'hFF7F
`define ACS_MASK_CH2_B     16'h0073
`define ACS_MASK_TEMP_B    16'h0070

// control / status bits
`define ACS_CTRL_CH2_BIT   1
`define ACS_CTRL_TEMP_BIT  0
`define ACS_STAT_BUSY_BIT  0
`define ACS_STAT_CHAN_BIT  1

`define ACS_RESET_SETUP    16'h0000

// base divisor of the converter clock, in system clocks
`define ACS_BASE_DIV       4
// system clock that the divisor applies to, in kHz
`define ACS_SYS_CLK_KHZ    4000
// bus clock, in kHz
`define ACS_BUS_CLK_KHZ    100000

`endif

/* File: src/acs_pkg.sv */
// types shared by the converter setup block
// assumes acs_regs.svh is on the include path
package acs_pkg;

    typedef struct packed {
        logic [4:0] gain_code;
        logic [2:0] clock_divider_code;
        logic [2:0] resolution_code;
        logic [3:0] coarse_offset_code;
        logic [2:0] bias_code;
        logic [1:0] reference_select;
    } acs_setup_t;

    typedef enum logic [1:0] {
        ACS_REF_SUPPLY   = 2'b00,
        ACS_REF_EXT_X2   = 2'b01,
        ACS_REF_BG_X4    = 2'b10
    } acs_ref_t;

    typedef enum logic [1:0] {
        ACS_IDLE  = 2'b00,
        ACS_CONV  = 2'b01,
        ACS_DONE  = 2'b10
    } acs_state_t;

    typedef struct packed {
        logic        valid;
        logic        temp_chan;
        acs_setup_t  setup;
        acs_ref_t    ref_src;
    } acs_conv_t;

endpackage

/* File: src/acs_clkdiv.sv */
// converter clock divider: one-cycle enable per converter clock
// assumes a steady code while run is high
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module acs_clkdiv
    import acs_pkg::*;
#(
    parameter int RATIO = 25
)(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       run,
    input  wire logic [2:0] code,
    output logic            tick
);
    initial
    begin
        if (RATIO < 1) $error("acs_clkdiv: RATIO must be at least 1");
    end

    localparam int CW = 24;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [CW-1:0] period;

    // period = ratio * 4 * 2**code bus clocks
    assign period = CW'(RATIO * `ACS_BASE_DIV) << code;
    assign tick   = run && (cnt_q == period - CW'(1));
    assign cnt_d  = (!run || tick) ? '0 : cnt_q + CW'(1);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end
endmodule
`default_nettype wire

/* File: src/acs_convlen.sv */
// converter clock count per conversion for a resolution code
// pure lookup, no state
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module acs_convlen
    import acs_pkg::*;
(
    input  wire logic [2:0]  resolution_code,
    output logic      [11:0] clocks,
    output logic      [4:0]  result_bits
);
    always_comb
    begin
        case (resolution_code)
            3'h0:
            begin
                clocks = 12'd256;
                result_bits = 5'd9;
            end
            3'h1:
            begin
                clocks = 12'd320;
                result_bits = 5'd10;
            end
            3'h2:
            begin
                clocks = 12'd512;
                result_bits = 5'd12;
            end
            3'h3:
            begin
                clocks = 12'd640;
                result_bits = 5'd13;
            end
            3'h4:
            begin
                clocks = 12'd800;
                result_bits = 5'd14;
            end
            3'h5:
            begin
                clocks = 12'd1280;
                result_bits = 5'd15;
            end
            3'h6:
            begin
                clocks = 12'd2048;
                result_bits = 5'd16;
            end
            default:
            begin
                // undefined code: longest setting
                clocks = 12'd2048;
                result_bits = 5'd16;
            end
        endcase
    end
endmodule
`default_nettype wire

/* File: src/acs_top.sv */
// converter setup registers for channel two and temperature, with
// conversion sequencing; AHB-Lite slave, zero wait states
//
// Notes on behaviour
// - ch2 A bits 15-11 gain, applied
// - ch2 A bits 10-8 clock code
// - ch2 A resolution 6-4, bit 7 unused
// - ch2 A offset sign 3, magnitude 2-0
// - ch2 B bias 6-4, reference 1-0
// - temp A mirrors channel layout
// - temp B bias only, low bits unused
// - gain: seventeen codes, others undefined
// - divisor four times two to code
// - resolution code sets clocks and bits
// - duration is clocks times divider period
// - offset is sign plus magnitude
// - reference: supply, 2x external, 4x bandgap
// - ch2 trigger converts, halts, self-clears
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module acs_top
    import acs_pkg::*;
#(
    // bus clocks per system clock tick
    parameter int SYS_RATIO = `ACS_BUS_CLK_KHZ / `ACS_SYS_CLK_KHZ
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output acs_conv_t        conv_setup,
    output logic             conv_active,
    output logic             conv_done,
    output logic             cpu_halt,
    output logic             gain_undefined
);
    initial
    begin
        if (SYS_RATIO < 1) $error("acs_top: SYS_RATIO must be >= 1");
    end

    // ==========================================================
    // bus address phase capture
    // ==========================================================
    logic        wr_pend_q;
    logic [7:0]  wr_idx_q;
    logic [7:0]  a_idx;
    logic        a_valid;
    logic        a_write;
    logic        a_read;

    assign a_idx   = haddr[9:2];
    assign a_valid = hsel && hready && htrans[1];
    assign a_write = a_valid && hwrite;
    assign a_read  = a_valid && !hwrite;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
        end
        else
        begin
            wr_pend_q <= a_write;
            wr_idx_q  <= a_idx;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ==========================================================
    // write decode
    // ==========================================================
    logic        we_ch2_a;
    logic        we_ch2_b;
    logic        we_tmp_a;
    logic        we_tmp_b;
    logic        we_ctrl;

    assign we_ch2_a = wr_pend_q && (wr_idx_q == `ACS_IDX_CH2_A);
    assign we_ch2_b = wr_pend_q && (wr_idx_q == `ACS_IDX_CH2_B);
    assign we_tmp_a = wr_pend_q && (wr_idx_q == `ACS_IDX_TEMP_A);
    assign we_tmp_b = wr_pend_q && (wr_idx_q == `ACS_IDX_TEMP_B);
    assign we_ctrl  = wr_pend_q && (wr_idx_q == `ACS_IDX_CTRL);

    // ==========================================================
    // setup registers
    // ==========================================================
    logic [15:0] ch2_a_q;
    logic [15:0] ch2_b_q;
    logic [15:0] tmp_a_q;
    logic [15:0] tmp_b_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ch2_a_q <= `ACS_RESET_SETUP;
            ch2_b_q <= `ACS_RESET_SETUP;
            tmp_a_q <= `ACS_RESET_SETUP;
            tmp_b_q <= `ACS_RESET_SETUP;
        end
        else
        begin
            if (we_ch2_a)
                ch2_a_q <= hwdata[15:0] & `ACS_MASK_A;
            if (we_ch2_b)
                ch2_b_q <= hwdata[15:0] & `ACS_MASK_CH2_B;
            if (we_tmp_a)
                tmp_a_q <= hwdata[15:0] & `ACS_MASK_A;
            if (we_tmp_b)
                tmp_b_q <= hwdata[15:0] & `ACS_MASK_TEMP_B;
        end
    end

    // ==========================================================
    // field extraction
    // ==========================================================
    acs_setup_t ch2_fields;
    acs_setup_t tmp_fields;

    assign ch2_fields.gain_code =
        ch2_a_q[`ACS_GAIN_MSB:`ACS_GAIN_LSB];
    assign ch2_fields.clock_divider_code =
        ch2_a_q[`ACS_CLK_MSB:`ACS_CLK_LSB];
    assign ch2_fields.resolution_code =
        ch2_a_q[`ACS_RES_MSB:`ACS_RES_LSB];
    assign ch2_fields.coarse_offset_code =
        {ch2_a_q[`ACS_OFS_SIGN], ch2_a_q[`ACS_OFS_MSB:`ACS_OFS_LSB]};
    assign ch2_fields.bias_code =
        ch2_b_q[`ACS_BIAS_MSB:`ACS_BIAS_LSB];
    assign ch2_fields.reference_select =
        ch2_b_q[`ACS_REF_MSB:`ACS_REF_LSB];

    assign tmp_fields.gain_code =
        tmp_a_q[`ACS_GAIN_MSB:`ACS_GAIN_LSB];
    assign tmp_fields.clock_divider_code =
        tmp_a_q[`ACS_CLK_MSB:`ACS_CLK_LSB];
    assign tmp_fields.resolution_code =
        tmp_a_q[`ACS_RES_MSB:`ACS_RES_LSB];
    assign tmp_fields.coarse_offset_code =
        {tmp_a_q[`ACS_OFS_SIGN], tmp_a_q[`ACS_OFS_MSB:`ACS_OFS_LSB]};
    assign tmp_fields.bias_code =
        tmp_b_q[`ACS_BIAS_MSB:`ACS_BIAS_LSB];
    // temperature has no reference select
    assign tmp_fields.reference_select = 2'b00;

    // ==========================================================
    // conversion sequencer
    // ==========================================================
    acs_state_t  state_q;
    acs_state_t  state_d;
    logic        trig_ch2_q;
    logic        trig_tmp_q;
    acs_conv_t   conv_q;
    logic [11:0] clk_cnt_q;
    logic [11:0] need_clocks;
    logic        adc_tick;
    logic        start;
    logic        sel_tmp;
    logic        last_tick;
    acs_setup_t  sel_fields;
    acs_ref_t    sel_ref;

    // channel two has priority over temperature
    assign sel_tmp    = !trig_ch2_q;
    assign sel_fields = sel_tmp ? tmp_fields : ch2_fields;
    assign start      = (state_q == ACS_IDLE) && (trig_ch2_q || trig_tmp_q);
    assign last_tick  = adc_tick && (clk_cnt_q == need_clocks - 12'd1);

    // reference: 00 supply, 01 twice external, 1x four times bandgap
    assign sel_ref = sel_fields.reference_select[1] ? ACS_REF_BG_X4 :
        (sel_fields.reference_select[0] ? ACS_REF_EXT_X2 :
        ACS_REF_SUPPLY);

    acs_convlen u_len (
        .resolution_code (conv_q.setup.resolution_code),
        .clocks          (need_clocks),
        .result_bits     ()
    );

    acs_clkdiv #(
        .RATIO (SYS_RATIO)
    ) u_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (state_q == ACS_CONV),
        .code    (conv_q.setup.clock_divider_code),
        .tick    (adc_tick)
    );

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ACS_IDLE:
                if (start)
                    state_d = ACS_CONV;
            ACS_CONV:
                if (last_tick)
                    state_d = ACS_DONE;
            ACS_DONE:
                state_d = ACS_IDLE;
            default:
                state_d = ACS_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q   <= ACS_IDLE;
            clk_cnt_q <= 12'd0;
            conv_q    <= '0;
        end
        else
        begin
            state_q <= state_d;
            if (start)
            begin
                // snapshot held for the whole conversion
                conv_q.valid     <= 1'b1;
                conv_q.temp_chan <= sel_tmp;
                conv_q.setup     <= sel_fields;
                conv_q.ref_src   <= sel_ref;
                clk_cnt_q        <= 12'd0;
            end
            else if (state_q == ACS_CONV && adc_tick)
                clk_cnt_q <= clk_cnt_q + 12'd1;
            if (state_q == ACS_DONE)
                conv_q.valid <= 1'b0;
        end
    end

    // triggers: set by software, cleared by hardware on completion
    logic done_ch2;
    logic done_tmp;

    assign done_ch2 = (state_q == ACS_DONE) && !conv_q.temp_chan;
    assign done_tmp = (state_q == ACS_DONE) && conv_q.temp_chan;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            trig_ch2_q <= 1'b0;
            trig_tmp_q <= 1'b0;
        end
        else
        begin
            // a new software set wins over the completion clear
            if (we_ctrl && hwdata[`ACS_CTRL_CH2_BIT])
                trig_ch2_q <= 1'b1;
            else if (done_ch2)
                trig_ch2_q <= 1'b0;
            if (we_ctrl && hwdata[`ACS_CTRL_TEMP_BIT])
                trig_tmp_q <= 1'b1;
            else if (done_tmp)
                trig_tmp_q <= 1'b0;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    logic gain_bad;

    // seventeen listed gain codes
    always_comb
    begin
        case (conv_q.setup.gain_code)
            5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
            5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h14, 5'h18, 5'h1C,
            5'h1E:
                gain_bad = 1'b0;
            default:
                gain_bad = 1'b1;
        endcase
    end

    assign conv_setup     = conv_q;
    assign conv_active    = (state_q == ACS_CONV);
    assign conv_done      = (state_q == ACS_DONE);
    assign cpu_halt       = trig_ch2_q || trig_tmp_q;
    assign gain_undefined = conv_q.valid && gain_bad;

    // ==========================================================
    // read data
    // ==========================================================
    logic [31:0] rd_d;
    logic [31:0] rdata_q;

    assign rd_d =
        (a_idx == `ACS_IDX_CH2_A)  ? {16'h0000, ch2_a_q} :
        (a_idx == `ACS_IDX_CH2_B)  ? {16'h0000, ch2_b_q} :
        (a_idx == `ACS_IDX_TEMP_A) ? {16'h0000, tmp_a_q} :
        (a_idx == `ACS_IDX_TEMP_B) ? {16'h0000, tmp_b_q} :
        (a_idx == `ACS_IDX_CTRL)   ?
            {30'h0, trig_ch2_q, trig_tmp_q} :
        (a_idx == `ACS_IDX_STATUS) ?
            {30'h0, conv_q.temp_chan, conv_active} :
        32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_q <= 32'h0000_0000;
        else if (a_read)
            rdata_q <= rd_d;
    end

    assign hrdata = rdata_q;
endmodule
`default_nettype wire

/* File: bench/acs_checker.sv */
// port assertions for the converter setup block
// bound to acs_top from tb_top; one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module acs_checker
    import acs_pkg::*;
#(
    parameter int SYS_RATIO = 1
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire acs_conv_t   conv_setup,
    input  wire logic        conv_active,
    input  wire logic        conv_done,
    input  wire logic        cpu_halt,
    input  wire logic        gain_undefined
);
    localparam int CLKS [8] = '{256, 320, 512, 640, 800, 1280, 2048, 2048};
    logic [31:0] cnt_q;
    logic [31:0] len;
    logic [4:0]  g;
    logic [1:0]  r;
    assign g = conv_setup.setup.gain_code;
    assign r = conv_setup.setup.reference_select;
    assign len = 32'(CLKS[conv_setup.setup.resolution_code] * SYS_RATIO
                 * (4 << conv_setup.setup.clock_divider_code));
    // active cycles of the running conversion
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            cnt_q <= 32'h0;
        else
            cnt_q <= conv_active ? cnt_q + 32'h1 : 32'h0;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_ctrl_wr;
        hsel && hready && htrans[1] && hwrite && haddr[9:2] == `ACS_IDX_CTRL;
    endsequence
    sequence s_ch2_trig;
        s_ctrl_wr ##1 hwdata[`ACS_CTRL_CH2_BIT];
    endsequence
    sequence s_temp_trig;
        s_ctrl_wr ##1 (hwdata[1:0] == 2'h1);
    endsequence

    property p_ch2_start;
        s_ch2_trig |-> ##[1:3] (conv_active && !conv_setup.temp_chan);
    endproperty
    a_ch2_start: assert property (p_ch2_start)
        else $error("channel two conversion did not start");
    property p_temp_start;
        s_temp_trig |-> ##[1:3] (conv_active && conv_setup.temp_chan);
    endproperty
    a_temp_start: assert property (p_temp_start)
        else $error("temperature conversion did not start");
    property p_halt;
        conv_active |-> cpu_halt;
    endproperty
    a_halt: assert property (p_halt)
        else $error("processor not halted during conversion");
    property p_hold;
        conv_active && $past(conv_active) |-> $stable(conv_setup);
    endproperty
    a_hold: assert property (p_hold)
        else $error("setup changed during conversion");
    property p_len;
        $fell(conv_active) |-> cnt_q == $past(len);
    endproperty
    a_len: assert property (p_len)
        else $error("conversion length wrong");
    property p_done;
        $fell(conv_active) |-> ##[0:1] conv_done;
    endproperty
    a_done: assert property (p_done)
        else $error("no completion after conversion");
    property p_pulse;
        conv_done |=> !conv_done;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("completion longer than one cycle");
    property p_release;
        conv_done |-> ##2 (!cpu_halt || conv_active);
    endproperty
    a_release: assert property (p_release)
        else $error("processor still halted after completion");
    property p_gain;
        conv_active |-> gain_undefined
            == !(g <= 5'h08 || g inside {10, 12, 14, 16, 20, 24, 28, 30});
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain code flag wrong");
    property p_ref;
        conv_active && !conv_setup.temp_chan |-> conv_setup.ref_src
            == (r[1] ? ACS_REF_BG_X4 : (r[0] ? ACS_REF_EXT_X2 : ACS_REF_SUPPLY));
    endproperty
    a_ref: assert property (p_ref)
        else $error("reference source wrong");
endmodule
`default_nettype wire

/* File: bench/acs_cpu_model.sv */
// processor model: single whole-word bus transfers to the setup block
// assumes hready is the slave's hreadyout; xfer starts after a rising edge
`timescale 1ns/1ps
`default_nettype none
module acs_cpu_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial
    begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'hA5A5A5A5;
    end
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge hclk); while (!hready);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (!hready);
        // released bus shows no stale value
        hwdata <= ~wd;
    endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the converter setup block
// needs acs_pkg, acs_regs.svh, acs_cpu_model and acs_checker
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module tb_top
    import acs_pkg::*;
;
    localparam int SYS_RATIO = 1;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    acs_conv_t   conv_setup;
    logic        conv_active, conv_done, cpu_halt, gain_undefined;
    logic [63:0] exp_q[$];
    logic [19:0] seen_setup;
    logic        rd_dp = 1'b0;
    int          act_cnt = 0;
    int          failures = 0;
    int          comparisons = 0;

    always #5 hclk = ~hclk;

    acs_top #(.SYS_RATIO(SYS_RATIO)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .conv_setup(conv_setup), .conv_active(conv_active),
        .conv_done(conv_done), .cpu_halt(cpu_halt),
        .gain_undefined(gain_undefined));
    acs_cpu_model cpu (
        .hclk(hclk), .hready(hreadyout), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================
    // monitor: read data and finished conversions
    always @(posedge hclk)
        rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
    always @(negedge hclk)
    begin
        if (rd_dp)
            check({32'h0, hrdata}, exp_q.pop_front());
        if (conv_active)
        begin
            act_cnt++;
            seen_setup = conv_setup.setup;
        end
        if (conv_done)
        begin
            check({11'h0, conv_setup.temp_chan, seen_setup, 32'(act_cnt)},
                  exp_q.pop_front());
            act_cnt = 0;
        end
    end

    // ==========================================
    // conversion: program setup, trigger, wait out the halt
    task automatic conv(input logic [1:0] trig, input logic [2:0] res,
                        input logic [2:0] clk, input int clocks);
        logic        tmp;
        logic [15:0] a;
        logic [15:0] b;
        logic [2:0]  bmin;
        int          n;
        tmp  = (trig == 2'h1);
        bmin = (clk == 3'h0) ? 3'h6 : (clk == 3'h1) ? 3'h4 : 3'h2;
        a = {5'($urandom), clk, 1'($urandom), res, 4'($urandom)};
        b = {9'($urandom), bmin + 3'($urandom % (8 - bmin)), 4'($urandom)};
        cpu.xfer(1'b1, tmp ? `ACS_IDX_TEMP_A : `ACS_IDX_CH2_A, {16'h0, a});
        cpu.xfer(1'b1, tmp ? `ACS_IDX_TEMP_B : `ACS_IDX_CH2_B, {16'h0, b});
        exp_q.push_back({11'h0, tmp, a[15:8], a[6:0], b[6:4],
                         tmp ? 2'h0 : b[1:0], 32'(clocks * SYS_RATIO * 4 << clk)});
        if (trig == 2'h3)
        begin
            // temperature runs after channel two, same settings
            cpu.xfer(1'b1, `ACS_IDX_TEMP_A, {16'h0, a});
            cpu.xfer(1'b1, `ACS_IDX_TEMP_B, {16'h0, b});
            exp_q.push_back({11'h0, 1'b1, a[15:8], a[6:0], b[6:4], 2'h0,
                             32'(clocks * SYS_RATIO * 4 << clk)});
        end
        cpu.xfer(1'b1, `ACS_IDX_CTRL, {30'h0, trig});
        n = 0;
        @(negedge hclk);
        while (!conv_done && n < 20000)
        begin
            @(negedge hclk);
            n++;
        end
        // processor stays off the bus until the halt drops
        while (cpu_halt && n < 20000)
        begin
            @(negedge hclk);
            n++;
        end
        if (n >= 20000)
            failures++;
        @(posedge hclk);
    endtask

    initial
    begin
        logic [7:0]  idx [4] = '{`ACS_IDX_CH2_A, `ACS_IDX_CH2_B,
                                 `ACS_IDX_TEMP_A, `ACS_IDX_TEMP_B};
        logic [15:0] msk [4] = '{`ACS_MASK_A, `ACS_MASK_CH2_B,
                                 `ACS_MASK_A, `ACS_MASK_TEMP_B};
        logic [31:0] wd [4];
        void'($urandom(32'hC315));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (idx[i])
        begin
            exp_q.push_back(64'h0);
            cpu.xfer(1'b0, idx[i], 32'h0);
        end
        foreach (idx[i])
        begin
            wd[i] = $urandom;
            cpu.xfer(1'b1, idx[i], wd[i]);
        end
        foreach (idx[i])
        begin
            exp_q.push_back({48'h0, wd[i][15:0] & msk[i]});
            cpu.xfer(1'b0, idx[i], 32'h0);
        end
        // unmapped place ignores writes and reads zero
        cpu.xfer(1'b1, 8'h07, 32'hFFFFFFFF);
        exp_q.push_back(64'h0);
        cpu.xfer(1'b0, 8'h07, 32'h0);
        conv(2'h2, 3'h0, 3'h0, 256);
        conv(2'h1, 3'h1, 3'h1, 320);
        conv(2'h3, 3'h6, 3'h0, 2048);
        conv(2'h1, 3'h7, 3'h0, 2048);
        conv(2'h2, 3'h2, 3'h2, 512);
        close_out();
    end

    initial
    begin
        repeat (60000) @(posedge hclk);
        failures++;
        close_out();
    end
endmodule

bind acs_top acs_checker #(.SYS_RATIO(SYS_RATIO)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .conv_setup(conv_setup), .conv_active(conv_active),
    .conv_done(conv_done), .cpu_halt(cpu_halt),
    .gain_undefined(gain_undefined));
`default_nettype wire
